// [phes_pkg.sv]
// Shared constants and types of the peak and hold event sequencer
package phes_pkg;

    localparam int CLK_PERIOD_NS = 50;
    localparam int OC_BLANK_NS   = 2500;
    localparam int AS_BLANK_NS   = 10000;
    localparam int OC_BLANK_CYC  = OC_BLANK_NS / CLK_PERIOD_NS;
    localparam int AS_BLANK_CYC  = AS_BLANK_NS / CLK_PERIOD_NS;

    localparam int DAC_W     = 7;
    localparam int DWELL_W   = 8;
    localparam int PRE_W     = 3;
    localparam int PRE_CNT_W = 7;
    localparam int BLANK_W   = 8;
    localparam int FLT_W     = 3;

    localparam int FLT_OC       = 0;
    localparam int FLT_AS_GATE  = 1;
    localparam int FLT_AS_CLAMP = 2;

    localparam logic [FLT_W-1:0][BLANK_W-1:0] BLANK_LIMITS = {
        BLANK_W'(AS_BLANK_CYC), BLANK_W'(AS_BLANK_CYC), BLANK_W'(OC_BLANK_CYC)};

    localparam logic [BLANK_W-1:0]   BLANK_ZERO = 8'h00;
    localparam logic [BLANK_W-1:0]   BLANK_ONE  = 8'h01;
    localparam logic [PRE_CNT_W-1:0] PRE_ZERO   = 7'h00;
    localparam logic [PRE_CNT_W-1:0] PRE_ONE    = 7'h01;
    localparam logic [DWELL_W-1:0]   DWELL_ZERO = 8'h00;
    localparam logic [DWELL_W-1:0]   DWELL_ONE  = 8'h01;
    localparam logic [FLT_W-1:0]     FLT_NONE   = 3'h0;
    localparam logic [DAC_W-1:0]     DAC_ZERO   = 7'h00;

    typedef enum logic [4:0] {
        ST_IDLE  = 5'h01,
        ST_GATE  = 5'h02,
        ST_G2C   = 5'h04,
        ST_CLAMP = 5'h08,
        ST_C2G   = 5'h10
    } phes_drive_type;

    typedef struct packed {
        logic [DAC_W-1:0] peak_high;
        logic [DAC_W-1:0] peak_low;
        logic [DAC_W-1:0] hold_high;
        logic [DAC_W-1:0] hold_low;
    } phes_levels_type;

    typedef struct packed {
        logic               gate_antisat_double;
        logic               clamp_antisat_double;
        logic               dwell_source_select;
        logic [PRE_W-1:0]   dwell_prescale_field;
        logic [DWELL_W-1:0] dwell_count;
    } phes_cfg_type;

    typedef struct packed {
        logic [BLANK_W-1:0] cnt;
        logic               hit;
    } phes_blank_type;

    typedef struct packed {
        phes_drive_type       drive;
        logic                 gate;
        logic                 clamp;
        logic                 hold_phase;
        logic                 run_prev;
        logic                 dwell_prev;
        logic [PRE_CNT_W-1:0] pre_cnt;
        logic [DWELL_W-1:0]   dwell_cnt;
        logic [FLT_W-1:0]     faults;
        logic                 fault_n;
        logic [DAC_W-1:0]     dac_upper;
        logic [DAC_W-1:0]     dac_lower;
        logic                 gate_sat_double;
        logic                 clamp_sat_double;
    } phes_core_type;

endpackage : phes_pkg

// [phes_blank.sv]
// Detection blanking timer: a condition must persist LIMIT cycles
`timescale 1ns/1ps
module phes_blank #(
    parameter logic [phes_pkg::BLANK_W-1:0] LIMIT = 8'h01
) (
    input  wire logic mclk_i,
    input  wire logic srst_i,
    input  wire logic cond_i,
    output logic      detect_o
);
    import phes_pkg::*;

    phes_blank_type q;
    phes_blank_type next_q;

    always_comb begin
        next_q = q;
        // A glitch shorter than the window restarts the count
        if (!cond_i) begin
            next_q.cnt = BLANK_ZERO;
            next_q.hit = 1'b0;
        end else if (!q.hit) begin
            next_q.cnt = q.cnt + BLANK_ONE;
            next_q.hit = (next_q.cnt == LIMIT);
        end
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            q <= '0;
        end else begin
            q <= next_q;
        end
    end

    assign detect_o = q.hit;

endmodule : phes_blank

// [phes_core.sv]
// Peak and hold event sequencer: dwell timing, drive order, fault blanking
`timescale 1ns/1ps
// Overview of operation
// - An event runs only while both drive inputs are high.
// - Peak and hold current levels and dwell length are programmable settings.
// - Settings arrive as parallel inputs; latched faults are read back on faults_o.
// - One configuration bit picks clocked or level dwell time base.
// - Clocked mode moves from peak to hold when dwell count expires.
// - Level mode picks peak or hold directly from the dwell input.
// - Either drive input low ends the event and turns both predrives off.
// - Bit 5 selects the gate antisaturation threshold, 1 doubles it.
// - Bit 4 selects the clamp antisaturation threshold, 1 doubles it.
// - Overcurrent is blanked 2.5 us before the fault output goes low.
// - Gate or clamp antisaturation is blanked 10 us before fault goes low.
// - Both drive inputs rising restart the dwell timer and enable the gate.
// - Level mode: dwell input low means peak, high means hold.
// - A three-bit prescaler divides the dwell clock before the dwell timer.
// - Upper level: gate off then clamp on; lower level: clamp off then gate on.
module phes_core (
    input  wire logic                      mclk_i,
    input  wire logic                      srst_i,
    input  wire logic                      drive_enable_input_i,
    input  wire logic                      drive_control_i,
    input  wire logic                      dwell_in_i,
    input  wire phes_pkg::phes_cfg_type    cfg_i,
    input  wire phes_pkg::phes_levels_type levels_i,
    input  wire logic                      above_upper_i,
    input  wire logic                      below_lower_i,
    input  wire logic                      overcurrent_i,
    input  wire logic                      antisat_gate_i,
    input  wire logic                      antisat_clamp_i,
    input  wire logic                      fault_clear_i,
    output logic                           gate_o,
    output logic                           clamp_o,
    output logic                           hold_phase_o,
    output logic [phes_pkg::DAC_W-1:0]     dac_upper_o,
    output logic [phes_pkg::DAC_W-1:0]     dac_lower_o,
    output logic                           gate_antisat_double_o,
    output logic                           clamp_antisat_double_o,
    output logic [phes_pkg::FLT_W-1:0]     faults_o,
    output logic                           fault_n_o
);
    import phes_pkg::*;

    phes_core_type    q;
    phes_core_type    next_q;
    logic [FLT_W-1:0] fault_cond;
    logic [FLT_W-1:0] fault_det;
    logic             run;
    logic             start;
    logic             dwell_edge;
    logic             dwell_expired;

    function automatic logic [PRE_CNT_W-1:0] pre_limit(input logic [PRE_W-1:0] field);
        pre_limit = (PRE_ONE << field) - PRE_ONE;
    endfunction : pre_limit

    function automatic logic [DAC_W-1:0] pick_level(input logic hold, input logic [DAC_W-1:0] peak_lvl,
                                                    input logic [DAC_W-1:0] hold_lvl);
        pick_level = hold ? hold_lvl : peak_lvl;
    endfunction : pick_level

    assign fault_cond = {antisat_clamp_i, antisat_gate_i, overcurrent_i};

    generate
        for (genvar i = 0; i < FLT_W; i++) begin : g_blank
            phes_blank #(
                .LIMIT(BLANK_LIMITS[i])
            ) u_blank (
                .mclk_i  (mclk_i),
                .srst_i  (srst_i),
                .cond_i  (fault_cond[i]),
                .detect_o(fault_det[i])
            );
        end
    endgenerate

    assign run           = drive_enable_input_i & drive_control_i;
    assign start         = run & ~q.run_prev;
    assign dwell_edge    = dwell_in_i & ~q.dwell_prev;
    assign dwell_expired = (q.dwell_cnt >= cfg_i.dwell_count);

    always_comb begin
        next_q            = q;
        next_q.run_prev   = run;
        next_q.dwell_prev = dwell_in_i;

        if (start) begin
            next_q.pre_cnt   = PRE_ZERO;
            next_q.dwell_cnt = DWELL_ZERO;
        end else if (!cfg_i.dwell_source_select && dwell_edge && !dwell_expired) begin
            if (q.pre_cnt >= pre_limit(cfg_i.dwell_prescale_field)) begin
                next_q.pre_cnt   = PRE_ZERO;
                next_q.dwell_cnt = q.dwell_cnt + DWELL_ONE;
            end else begin
                next_q.pre_cnt = q.pre_cnt + PRE_ONE;
            end
        end

        if (!run) begin
            next_q.hold_phase = 1'b0;
        end else if (cfg_i.dwell_source_select) begin
            next_q.hold_phase = dwell_in_i;
        end else begin
            next_q.hold_phase = !start && dwell_expired;
        end

        next_q.dac_upper = pick_level(next_q.hold_phase, levels_i.peak_high, levels_i.hold_high);
        next_q.dac_lower = pick_level(next_q.hold_phase, levels_i.peak_low, levels_i.hold_low);

        next_q.gate_sat_double  = cfg_i.gate_antisat_double;
        next_q.clamp_sat_double = cfg_i.clamp_antisat_double;

        next_q.faults  = (q.faults & ~{FLT_W{fault_clear_i}}) | fault_det;
        next_q.fault_n = (next_q.faults == FLT_NONE);

        if (!run || fault_det != FLT_NONE) begin
            // Fault stops drive; only a fresh rising condition restarts it
            next_q.drive = ST_IDLE;
        end else begin
            case (q.drive)
                ST_IDLE:  next_q.drive = start ? ST_GATE : ST_IDLE;
                ST_GATE:  next_q.drive = above_upper_i ? ST_G2C : ST_GATE;
                ST_G2C:   next_q.drive = ST_CLAMP;
                ST_CLAMP: next_q.drive = below_lower_i ? ST_C2G : ST_CLAMP;
                ST_C2G:   next_q.drive = ST_GATE;
                default:  next_q.drive = ST_IDLE;
            endcase
        end
        next_q.gate  = (next_q.drive == ST_GATE);
        next_q.clamp = (next_q.drive == ST_CLAMP);
    end

    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            q         <= '0;
            q.drive   <= ST_IDLE;
            q.fault_n <= 1'b1;
        end else begin
            q <= next_q;
        end
    end

    assign gate_o                 = q.gate;
    assign clamp_o                = q.clamp;
    assign hold_phase_o           = q.hold_phase;
    assign dac_upper_o            = q.dac_upper;
    assign dac_lower_o            = q.dac_lower;
    assign gate_antisat_double_o  = q.gate_sat_double;
    assign clamp_antisat_double_o = q.clamp_sat_double;
    assign faults_o               = q.faults;
    assign fault_n_o              = q.fault_n;

    // Consecutive-high counters used only by the checks below
    logic [BLANK_W-1:0] oc_run;
    logic [BLANK_W-1:0] asg_run;
    always_ff @(posedge mclk_i) begin
        if (srst_i) begin
            oc_run  <= BLANK_ZERO;
            asg_run <= BLANK_ZERO;
        end else begin
            oc_run  <= !overcurrent_i ? BLANK_ZERO : (oc_run == 8'hff ? oc_run : oc_run + BLANK_ONE);
            asg_run <= !antisat_gate_i ? BLANK_ZERO : (asg_run == 8'hff ? asg_run : asg_run + BLANK_ONE);
        end
    end

    AST_ABORT_OFF: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(drive_enable_input_i && drive_control_i) |=> !gate_o && !clamp_o)
        else $error("Predrive still on after drive input low");

    AST_IDLE_PEAK: assert property (@(posedge mclk_i) disable iff (srst_i)
        !(drive_enable_input_i && drive_control_i) ##1 !(drive_enable_input_i && drive_control_i)
        |=> !hold_phase_o && !gate_o && !clamp_o)
        else $error("Idle block not in peak with predrives off");

    AST_START_GATE: assert property (@(posedge mclk_i) disable iff (srst_i)
        start && fault_det == FLT_NONE && !cfg_i.dwell_source_select && cfg_i.dwell_count != DWELL_ZERO
        |=> gate_o && !clamp_o && !hold_phase_o)
        else $error("Event start did not enable gate in peak phase");

    AST_GATE_TO_CLAMP: assert property (@(posedge mclk_i) disable iff (srst_i)
        gate_o && above_upper_i && run && fault_det == FLT_NONE
        |=> !gate_o && !clamp_o ##1 (clamp_o || !$past(run) || $past(fault_det) != FLT_NONE))
        else $error("Gate to clamp order broken");

    AST_CLAMP_TO_GATE: assert property (@(posedge mclk_i) disable iff (srst_i)
        $rose(gate_o) |-> !$past(clamp_o))
        else $error("Gate rose while clamp was on");

    AST_LEVEL_PHASE: assert property (@(posedge mclk_i) disable iff (srst_i)
        run && cfg_i.dwell_source_select |=> hold_phase_o == $past(dwell_in_i))
        else $error("Level mode phase does not follow dwell input");

    AST_DWELL_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
        run && !start && !cfg_i.dwell_source_select && dwell_expired |=> hold_phase_o)
        else $error("Dwell expiry did not select hold");

    AST_OC_EARLY: assert property (@(posedge mclk_i) disable iff (srst_i)
        !faults_o[FLT_OC] && oc_run < BLANK_W'(OC_BLANK_CYC) |=> !faults_o[FLT_OC])
        else $error("Overcurrent latched before blanking time");

    AST_OC_LATE: assert property (@(posedge mclk_i) disable iff (srst_i)
        oc_run >= BLANK_W'(OC_BLANK_CYC) |=> faults_o[FLT_OC] && !fault_n_o)
        else $error("Overcurrent not flagged after blanking time");

    AST_AS_TIMING: assert property (@(posedge mclk_i) disable iff (srst_i)
        !faults_o[FLT_AS_GATE] && asg_run == BLANK_W'(AS_BLANK_CYC - 1) && antisat_gate_i
        |=> !faults_o[FLT_AS_GATE] ##1 faults_o[FLT_AS_GATE])
        else $error("Gate antisaturation blanking time wrong");

    AST_FAULT_HOLD: assert property (@(posedge mclk_i) disable iff (srst_i)
        faults_o != FLT_NONE && !fault_clear_i |=> faults_o != FLT_NONE && !fault_n_o)
        else $error("Latched fault lost without clear");

endmodule : phes_core

// [phes_host_model.sv]
// Host model: drive inputs and dwell time base
`timescale 1ns/1ps
module phes_host_model (
    input  wire logic       mclk_i,
    input  wire logic       en_req_i,
    input  wire logic       ctl_req_i,
    input  wire logic       level_mode_i,
    input  wire logic       level_i,
    input  wire logic [3:0] half_i,
    output logic            drive_enable_input_o,
    output logic            drive_control_o,
    output logic            dwell_o
);
    logic [3:0] cnt    = 4'h0;
    logic       en_q   = 1'b0;
    logic       ctl_q  = 1'b0;
    logic       mode_q = 1'b0;
    logic       lvl_q  = 1'b0;
    logic [3:0] half_q = 4'h1;
    initial begin
        drive_enable_input_o = 1'b0;
        drive_control_o      = 1'b0;
        dwell_o              = 1'b0;
    end
    // Requests taken on the rising edge, clear of the bench's falling-edge updates
    always @(posedge mclk_i) begin
        en_q   <= en_req_i;
        ctl_q  <= ctl_req_i;
        mode_q <= level_mode_i;
        lvl_q  <= level_i;
        half_q <= half_i;
    end
    always @(negedge mclk_i) begin
        drive_enable_input_o <= en_q;
        drive_control_o      <= ctl_q;
        if (mode_q) begin
            dwell_o <= lvl_q;
        end else if (!(en_q && ctl_q)) begin
            // Clock stands still between events
            dwell_o <= 1'b0;
            cnt     <= 4'h0;
        end else if (cnt == half_q - 4'h1) begin
            dwell_o <= ~dwell_o;
            cnt     <= 4'h0;
        end else begin
            cnt <= cnt + 4'h1;
        end
    end
endmodule : phes_host_model

// [tb_phes_core.sv]
// Testbench of the peak and hold event sequencer
`timescale 1ns/1ps
module tb_phes_core;
    import phes_pkg::*;
    logic mclk_i = 1'b0, srst_i = 1'b1, en = 1'b0, ctl = 1'b0, lvl = 1'b0;
    logic above = 1'b0, below = 1'b0, clr = 1'b0;
    logic [2:0] det = 3'h0;
    logic [3:0] half = 4'h1;
    logic ena, ctrl, dwell, gate_o, clamp_o, hold_o, gdbl, cdbl, fault_n_o;
    logic [DAC_W-1:0] dac_up, dac_lo;
    logic [FLT_W-1:0] faults_o;
    phes_cfg_type cfg = '0;
    phes_levels_type lv = {7'h64, 7'h32, 7'h28, 7'h14};
    int err_count = 0;
    int n_tests = 0;
    int tbl [2][5] = '{'{0, 2, 1, 3, 9}, '{1, 3, 2, 18, 30}};
    always #25 mclk_i = ~mclk_i;
    phes_host_model HOST (.mclk_i(mclk_i), .en_req_i(en), .ctl_req_i(ctl), .level_mode_i(cfg.dwell_source_select),
        .level_i(lvl), .half_i(half), .drive_enable_input_o(ena), .drive_control_o(ctrl), .dwell_o(dwell));
    phes_core DUT (.mclk_i(mclk_i), .srst_i(srst_i), .drive_enable_input_i(ena), .drive_control_i(ctrl),
        .dwell_in_i(dwell), .cfg_i(cfg), .levels_i(lv), .above_upper_i(above), .below_lower_i(below),
        .overcurrent_i(det[0]), .antisat_gate_i(det[1]), .antisat_clamp_i(det[2]), .fault_clear_i(clr),
        .gate_o(gate_o), .clamp_o(clamp_o), .hold_phase_o(hold_o), .dac_upper_o(dac_up), .dac_lower_o(dac_lo),
        .gate_antisat_double_o(gdbl), .clamp_antisat_double_o(cdbl), .faults_o(faults_o), .fault_n_o(fault_n_o));
    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            err_count++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic cyc(input int n);
        repeat (n) @(negedge mclk_i);
    endtask : cyc
    function automatic logic sig(input int s);
        return (s == 0) ? gate_o : clamp_o;
    endfunction : sig
    // Bounded wait, since output latency is a design choice
    task automatic wait_sig(input int s, input logic v);
        for (int i = 0; i < 4 && sig(s) !== v; i++) cyc(1);
        check(sig(s), v);
    endtask : wait_sig
    task automatic results;
        $display("Checks %0d mismatches %0d", n_tests, err_count);
        if (err_count == 0 && n_tests > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask : results
    initial begin
        #(3000 * 50);
        err_count++;
        $display("Watchdog expired");
        results();
    end
    initial begin
        cyc(10);
        srst_i = 1'b0;
        cyc(1);
        check({gate_o, clamp_o, hold_o, fault_n_o, faults_o}, 8'h08);
        cfg.dwell_count = 8'hff;
        cfg.dwell_prescale_field = 3'h7;
        en = 1'b1;
        ctl = 1'b1;
        wait_sig(0, 1'b1);
        check({hold_o, dac_up}, {1'b0, lv.peak_high});
        above = 1'b1;
        wait_sig(0, 1'b0);
        check(clamp_o, 1'b0);
        cyc(1);
        check(clamp_o, 1'b1);
        above = 1'b0;
        below = 1'b1;
        wait_sig(1, 1'b0);
        check(gate_o, 1'b0);
        cyc(1);
        check(gate_o, 1'b1);
        below = 1'b0;
        ctl = 1'b0;
        cyc(3);
        check({gate_o, clamp_o, hold_o}, 8'h00);
        $display("Test peak switching done");
        for (int k = 0; k < 2; k++) begin
            cfg.dwell_prescale_field = PRE_W'(tbl[k][0]);
            cfg.dwell_count = DWELL_W'(tbl[k][1]);
            half = 4'(tbl[k][2]);
            cyc(2);
            ctl = 1'b1;
            en = 1'b1;
            cyc(tbl[k][3]);
            check(hold_o, 1'b0);
            cyc(tbl[k][4] - tbl[k][3]);
            check(hold_o, 1'b1);
            check({1'b0, dac_up}, {1'b0, lv.hold_high});
            check({1'b0, dac_lo}, {1'b0, lv.hold_low});
            en = 1'b0;
            cyc(3);
            check(hold_o, 1'b0);
        end
        $display("Test clocked dwell done");
        cfg.dwell_source_select = 1'b1;
        en = 1'b1;
        cyc(4);
        check(hold_o, 1'b0);
        lvl = 1'b1;
        cyc(3);
        check({hold_o, dac_up}, {1'b1, lv.hold_high});
        lvl = 1'b0;
        cyc(3);
        check(hold_o, 1'b0);
        en = 1'b0;
        $display("Test level dwell done");
        for (int i = 0; i < 4; i++) begin
            {cfg.gate_antisat_double, cfg.clamp_antisat_double} = 2'(i);
            cyc(2);
            check({gdbl, cdbl}, 8'(i));
        end
        $display("Test thresholds done");
        for (int k = 0; k < FLT_W; k++) begin
            en = 1'b1;
            cyc(4);
            det[k] = 1'b1;
            cyc(int'(BLANK_LIMITS[k]));
            check(fault_n_o, 1'b1);
            cyc(1);
            check(fault_n_o, 1'b0);
            check(faults_o, 8'(1 << k));
            det[k] = 1'b0;
            cyc(2);
            check(gate_o, 1'b0);
            clr = 1'b1;
            cyc(1);
            clr = 1'b0;
            cyc(2);
            check({fault_n_o, faults_o}, 8'h08);
            en = 1'b0;
            cyc(2);
        end
        $display("Test fault blanking done");
        results();
    end
endmodule : tb_phes_core
